//--- core/intc_pkg.sv
// package of the external and on-chip interrupt priority and vector controller
// assumes one 20 MHz clock and a 16-bit register port with 8-bit byte addresses
package intc_pkg;

  // --------------------------------------------------------------------------
  // sizes
  // --------------------------------------------------------------------------
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 16;
  localparam int PIN_N    = 4;
  localparam int PERIPH_N = 32;
  localparam int FIELD_N  = 16;
  localparam int VEC_W    = 8;
  localparam int LVL_W    = 4;
  localparam int CS_N     = 5;
  localparam int VIDX_W   = 5;

  // --------------------------------------------------------------------------
  // register offsets
  // --------------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_SENSE    = 8'h02;
  localparam logic [7:0] OFS_EXT_PRI  = 8'h04;
  localparam logic [7:0] OFS_PRI_A    = 8'h06;
  localparam logic [7:0] OFS_PRI_B    = 8'h08;
  localparam logic [7:0] OFS_PRI_D    = 8'h0A;
  localparam logic [7:0] OFS_PRI_E    = 8'h0C;
  localparam logic [7:0] OFS_VBR_HI   = 8'h0E;
  localparam logic [7:0] OFS_VBR_LO   = 8'h10;
  localparam logic [7:0] OFS_MASK     = 8'h12;
  localparam logic [7:0] OFS_LAST_VEC = 8'h14;
  localparam logic [7:0] OFS_VEC_BASE = 8'h40;

  // --------------------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------------------
  localparam int CTRL_VSEL_BIT    = 0;
  localparam int CTRL_PPM_BIT     = 1;
  localparam int CTRL_NONMASK_EDGE_SELECT_BIT    = 8;
  localparam int CTRL_NMI_LVL_BIT = 15;
  localparam int SENSE_FLAG_LSB   = 8;
  localparam int SENSE_PIN_LSB    = 12;
  localparam int VEC_IDX_LSB      = 1;

  // --------------------------------------------------------------------------
  // reset values and fixed codes
  // --------------------------------------------------------------------------
  localparam logic [15:0] RST_CTRL     = 16'h0000;
  localparam logic [7:0]  RST_SENSE    = 8'h00;
  localparam logic [15:0] RST_PRI      = 16'h0000;
  localparam logic [31:0] RST_VBR      = 32'h0000_0000;
  localparam logic [3:0]  RST_MASK     = 4'hF;
  localparam logic [7:0]  AUTOVEC_BASE = 8'h40;
  localparam logic [7:0]  NMI_VECTOR   = 8'h0B;
  localparam logic [4:0]  NMI_LEVEL    = 5'h10;
  localparam logic [3:0]  NMI_MASK     = 4'hF;

  typedef enum logic [1:0] {
    SENSE_LOW  = 2'b00,
    SENSE_FALL = 2'b01,
    SENSE_RISE = 2'b10,
    SENSE_BOTH = 2'b11
  } sense_type;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_FETCH = 2'b01,
    ST_VREAD = 2'b10,
    ST_ISSUE = 2'b11
  } state_type;

  typedef enum logic [1:0] {
    KIND_NONE   = 2'b00,
    KIND_NMI    = 2'b01,
    KIND_PIN    = 2'b10,
    KIND_PERIPH = 2'b11
  } kind_type;

endpackage

//--- core/vec_mem_if.sv
// carrier between the controller and its peripheral vector store
// assumes both ends run on the controller clock
`timescale 1ns/10ps
interface vec_mem_if;
  import intc_pkg::*;
  logic              wr_en;
  logic [VIDX_W-1:0] wr_addr;
  logic [VEC_W-1:0]  wr_data;
  logic [VIDX_W-1:0] bus_addr;
  logic [VEC_W-1:0]  bus_data;
  logic [VIDX_W-1:0] eng_addr;
  logic [VEC_W-1:0]  eng_data;
  modport owner (output wr_en, wr_addr, wr_data, bus_addr, eng_addr,
                 input bus_data, eng_data);
  modport store (input wr_en, wr_addr, wr_data, bus_addr, eng_addr,
                 output bus_data, eng_data);
endinterface

//--- core/vec_store.sv
// vector numbers of the on-chip sources, one write port, two registered read ports
// assumes the owner holds read addresses at least one cycle
`timescale 1ns/10ps
module vec_store
  import intc_pkg::*;
(
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic ce,
  vec_mem_if.store  mem
);
  logic [VEC_W-1:0] cells [PERIPH_N];

  always_ff @(posedge clk) begin
    if (ce && mem.wr_en) begin
      cells[mem.wr_addr] <= mem.wr_data;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mem.bus_data <= '0;
      mem.eng_data <= '0;
    end else if (ce) begin
      mem.bus_data <= cells[mem.bus_addr];
      mem.eng_data <= cells[mem.eng_addr];
    end
  end
endmodule

//--- core/pin_sense.sv
// one request pin in per-pin mode: low level or edge sensing with a sticky flag
// assumes the pin is synchronous to clk
`timescale 1ns/10ps
module pin_sense
  import intc_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      reset_n,
  input  wire logic      ce,
  input  wire logic      pin_level,
  input  wire sense_type sense_mode,
  input  wire logic      enable,
  input  wire logic      clear,
  output logic           flag,
  output logic           pending
);
  logic prev;
  logic hit;

  always_comb begin
    unique case (sense_mode)
      SENSE_LOW:  hit = 1'b0;
      SENSE_FALL: hit = prev & ~pin_level;
      SENSE_RISE: hit = ~prev & pin_level;
      SENSE_BOTH: hit = prev ^ pin_level;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prev <= 1'b1;
    end else if (ce) begin
      prev <= pin_level;
    end
  end

  // edge flag: a new edge wins over a clear in the same cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flag <= 1'b0;
    end else if (ce) begin
      if (enable && hit) begin
        flag <= 1'b1;
      end else if (clear || !enable) begin
        flag <= 1'b0;
      end
    end
  end

  assign pending = enable & ((sense_mode == SENSE_LOW) ? ~pin_level : flag);
endmodule

//--- core/intc_core.sv
// interrupt priority and vector controller: request pins, on-chip sources, nmi
// assumes synchronous inputs, one clock, a cpu that takes exc_start as a pulse
//
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/10ps
module intc_core
  import intc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic [DATA_W-1:0]      rdata,
  input  wire logic              nmi_pin,
  input  wire logic [PIN_N-1:0]  request_pins,
  input  wire logic [PERIPH_N-1:0] periph_req,
  input  wire logic [VEC_W-1:0]  vector_in_lines,
  input  wire logic              wait_n,
  input  wire logic [CS_N-1:0]   bus_chip_select_n,
  output logic [CS_N-1:0]        chip_select_outs,
  output logic [LVL_W-1:0]       accepted_level_out,
  output logic                   vector_fetch_strobe_n,
  output logic                   exc_start,
  output logic [LVL_W-1:0]       exc_level,
  output logic [VEC_W-1:0]       exc_vector,
  output logic [31:0]            exc_addr,
  output logic [LVL_W-1:0]       status_mask_field
);

  // --------------------------------------------------------------------------
  // registers and state
  // --------------------------------------------------------------------------
  logic [15:0]       intc_control_reg;
  logic [7:0]        pin_sense_select_fields;
  logic [15:0]       ext_pin_priority_reg;
  logic [15:0]       periph_priority_reg_a;
  logic [15:0]       periph_priority_reg_b;
  logic [15:0]       periph_priority_reg_d;
  logic [15:0]       periph_priority_reg_e;
  logic [31:0]       vector_base_reg;
  logic [VEC_W-1:0]  last_vector;
  state_type         state;
  kind_type          src_kind;
  logic [VIDX_W-1:0] src_index;
  logic [LVL_W-1:0]  src_level;
  logic [VEC_W-1:0]  src_vector;
  logic              nmi_prev;
  logic              nmi_flag;
  logic              vec_read_d;

  logic              per_pin_mode_select;
  logic              vector_source_select;
  logic              nonmask_edge_select;
  logic              wr_hit_vec;
  logic              rd_hit_vec;
  logic [PIN_N-1:0]  pin_flag;
  logic [PIN_N-1:0]  pin_pending;
  logic [PIN_N-1:0]  pin_clear;
  logic [63:0]       periph_fields;
  logic [3:0]        enc_level;
  logic [4:0]        best_level;
  kind_type          best_kind;
  logic [VIDX_W-1:0] best_index;
  logic              accept;
  logic [VEC_W-1:0]  next_vector;
  logic [DATA_W-1:0] next_rdata;
  logic              nmi_edge;

  vec_mem_if vmem ();

  assign per_pin_mode_select  = intc_control_reg[CTRL_PPM_BIT];
  assign vector_source_select = intc_control_reg[CTRL_VSEL_BIT];
  assign nonmask_edge_select  = intc_control_reg[CTRL_NONMASK_EDGE_SELECT_BIT];
  assign wr_hit_vec = wr && (addr >= OFS_VEC_BASE) && !addr[7];
  assign rd_hit_vec = rd && (addr >= OFS_VEC_BASE) && !addr[7];

  // --------------------------------------------------------------------------
  // register writes
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      intc_control_reg        <= RST_CTRL;
      pin_sense_select_fields <= RST_SENSE;
      ext_pin_priority_reg    <= RST_PRI;
      periph_priority_reg_a   <= RST_PRI;
      periph_priority_reg_b   <= RST_PRI;
      periph_priority_reg_d   <= RST_PRI;
      periph_priority_reg_e   <= RST_PRI;
      vector_base_reg         <= RST_VBR;
    end else if (ce && wr) begin
      unique case (addr)
        OFS_CTRL: begin
          intc_control_reg <= wdata & 16'h0103;
        end
        OFS_SENSE:   pin_sense_select_fields <= wdata[7:0];
        OFS_EXT_PRI: ext_pin_priority_reg <= wdata;
        OFS_PRI_A:   periph_priority_reg_a <= wdata;
        OFS_PRI_B:   periph_priority_reg_b <= wdata;
        OFS_PRI_D:   periph_priority_reg_d <= wdata;
        OFS_PRI_E:   periph_priority_reg_e <= wdata;
        OFS_VBR_HI:  vector_base_reg[31:16] <= wdata;
        OFS_VBR_LO:  vector_base_reg[15:0] <= wdata;
        default: begin
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // register reads, data one cycle after the strobe
  // --------------------------------------------------------------------------
  always_comb begin
    next_rdata = '0;
    unique case (addr)
      OFS_CTRL: begin
        next_rdata = intc_control_reg;
        next_rdata[CTRL_NMI_LVL_BIT] = nmi_pin;
      end
      OFS_SENSE: begin
        next_rdata[7:0] = pin_sense_select_fields;
        next_rdata[SENSE_FLAG_LSB +: PIN_N] = pin_flag;
        next_rdata[SENSE_PIN_LSB +: PIN_N] = request_pins;
      end
      OFS_EXT_PRI:  next_rdata = ext_pin_priority_reg;
      OFS_PRI_A:    next_rdata = periph_priority_reg_a;
      OFS_PRI_B:    next_rdata = periph_priority_reg_b;
      OFS_PRI_D:    next_rdata = periph_priority_reg_d;
      OFS_PRI_E:    next_rdata = periph_priority_reg_e;
      OFS_VBR_HI:   next_rdata = vector_base_reg[31:16];
      OFS_VBR_LO:   next_rdata = vector_base_reg[15:0];
      OFS_MASK:     next_rdata = {12'h000, status_mask_field};
      OFS_LAST_VEC: next_rdata = {6'h00, state, last_vector};
      default:      next_rdata = '0;
    endcase
  end

  logic [DATA_W-1:0] reg_rdata;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata  <= '0;
      vec_read_d <= 1'b0;
    end else if (ce) begin
      reg_rdata  <= rd ? next_rdata : '0;
      vec_read_d <= rd_hit_vec;
    end
  end

  assign rdata = vec_read_d ? {8'h00, vmem.bus_data} : reg_rdata;

  // --------------------------------------------------------------------------
  // per-source vector store
  // --------------------------------------------------------------------------
  assign vmem.wr_en    = ce && wr_hit_vec;
  assign vmem.wr_addr  = addr[VEC_IDX_LSB +: VIDX_W];
  assign vmem.wr_data  = {1'b0, wdata[6:0]};
  assign vmem.bus_addr = addr[VEC_IDX_LSB +: VIDX_W];
  assign vmem.eng_addr = src_index;

  vec_store u_store (
    .clk     (clk),
    .reset_n (reset_n),
    .ce      (ce),
    .mem     (vmem.store)
  );

  // --------------------------------------------------------------------------
  // request pins in per-pin mode
  // --------------------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < PIN_N; i++) begin
      pin_clear[i] = (accept && best_kind == KIND_PIN && best_index == VIDX_W'(i))
                  || (wr && addr == OFS_SENSE && !wdata[SENSE_FLAG_LSB + i]);
    end
  end

  genvar g;
  generate
    for (g = 0; g < PIN_N; g++) begin : pins
      pin_sense u_sense (
        .clk        (clk),
        .reset_n    (reset_n),
        .ce         (ce),
        .pin_level  (request_pins[g]),
        .sense_mode (sense_type'(pin_sense_select_fields[2*g +: 2])),
        .enable     (per_pin_mode_select),
        .clear      (pin_clear[g]),
        .flag       (pin_flag[g]),
        .pending    (pin_pending[g])
      );
    end
  endgenerate

  // --------------------------------------------------------------------------
  // nmi edge latch
  // --------------------------------------------------------------------------
  assign nmi_edge = nonmask_edge_select ? (nmi_pin & ~nmi_prev)
                                        : (~nmi_pin & nmi_prev);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      nmi_prev <= 1'b1;
      nmi_flag <= 1'b0;
    end else if (ce) begin
      nmi_prev <= nmi_pin;
      if (nmi_edge) begin
        nmi_flag <= 1'b1;
      end else if (accept && best_kind == KIND_NMI) begin
        nmi_flag <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // priority resolution
  // --------------------------------------------------------------------------
  assign periph_fields = {periph_priority_reg_a, periph_priority_reg_b,
                          periph_priority_reg_d, periph_priority_reg_e};
  assign enc_level = ~request_pins;

  always_comb begin
    best_level = '0;
    best_kind  = KIND_NONE;
    best_index = '0;
    if (nmi_flag) begin
      best_level = NMI_LEVEL;
      best_kind  = KIND_NMI;
    end else begin
      if (per_pin_mode_select) begin
        for (int i = 0; i < PIN_N; i++) begin
          // strict compare keeps the earlier source on a tie
          if (pin_pending[i] && {1'b0, ext_pin_priority_reg[4*i +: 4]} > best_level) begin
            best_level = {1'b0, ext_pin_priority_reg[4*i +: 4]};
            best_kind  = KIND_PIN;
            best_index = VIDX_W'(i);
          end
        end
      end else if (enc_level != 4'h0) begin
        best_level = {1'b0, enc_level};
        best_kind  = KIND_PIN;
        best_index = '0;
      end
      for (int j = 0; j < PERIPH_N; j++) begin
        // two sources per field, lower index ranked first
        if (periph_req[j] && {1'b0, periph_fields[63 - 4*(j/2) -: 4]} > best_level) begin
          best_level = {1'b0, periph_fields[63 - 4*(j/2) -: 4]};
          best_kind  = KIND_PERIPH;
          best_index = VIDX_W'(j);
        end
      end
    end
  end

  // level 0 never beats the start value
  assign accept = (state == ST_IDLE) && (best_kind == KIND_NMI
               || (best_kind != KIND_NONE && best_level > {1'b0, status_mask_field}));

  // --------------------------------------------------------------------------
  // acceptance sequencer
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state     <= ST_IDLE;
      src_kind  <= KIND_NONE;
      src_index <= '0;
      src_level <= '0;
    end else if (ce) begin
      unique case (state)
        ST_IDLE: begin
          if (accept) begin
            src_kind  <= best_kind;
            src_index <= best_index;
            src_level <= (best_kind == KIND_NMI) ? NMI_MASK : best_level[3:0];
            if (best_kind == KIND_PIN && vector_source_select) begin
              state <= ST_FETCH;
            end else if (best_kind == KIND_PERIPH) begin
              state <= ST_VREAD;
            end else begin
              state <= ST_ISSUE;
            end
          end
        end
        ST_FETCH: begin
          if (wait_n) begin
            state <= ST_ISSUE;
          end
        end
        ST_VREAD: state <= ST_ISSUE;
        ST_ISSUE: state <= ST_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // external vector fetch pins
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      vector_fetch_strobe_n <= 1'b1;
      accepted_level_out    <= '0;
    end else if (ce) begin
      if (state == ST_IDLE && accept && best_kind == KIND_PIN && vector_source_select) begin
        vector_fetch_strobe_n <= 1'b0;
        accepted_level_out    <= best_level[3:0];
      end else if (state == ST_FETCH && wait_n) begin
        vector_fetch_strobe_n <= 1'b1;
        accepted_level_out    <= '0;
      end
    end
  end

  assign chip_select_outs = vector_fetch_strobe_n ? bus_chip_select_n
                                                  : {CS_N{1'b1}};

  // --------------------------------------------------------------------------
  // vector capture
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      src_vector <= '0;
    end else if (ce) begin
      if (state == ST_IDLE && accept) begin
        src_vector <= AUTOVEC_BASE + VEC_W'(best_level[3:1]);
      end else if (state == ST_FETCH && wait_n) begin
        src_vector <= vector_in_lines;
      end
    end
  end

  always_comb begin
    unique case (src_kind)
      KIND_NMI:    next_vector = NMI_VECTOR;
      KIND_PERIPH: next_vector = vmem.eng_data;
      KIND_PIN:    next_vector = src_vector;
      KIND_NONE:   next_vector = '0;
    endcase
  end

  // --------------------------------------------------------------------------
  // exception start toward the cpu
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      exc_start   <= 1'b0;
      exc_level   <= '0;
      exc_vector  <= '0;
      exc_addr    <= '0;
      last_vector <= '0;
    end else if (ce) begin
      exc_start <= (state == ST_ISSUE);
      if (state == ST_ISSUE) begin
        exc_level   <= src_level;
        exc_vector  <= next_vector;
        last_vector <= next_vector;
        exc_addr    <= vector_base_reg + {22'h0, next_vector, 2'b00};
      end
    end
  end

  // status mask: hardware load wins over a software write in the same cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      status_mask_field <= RST_MASK;
    end else if (ce) begin
      if (state == ST_ISSUE) begin
        status_mask_field <= src_level;
      end else if (wr && addr == OFS_MASK) begin
        status_mask_field <= wdata[3:0];
      end
    end
  end

endmodule

//--- tb/intc_core_sva.sv
// checker of the controller's vector fetch and exception start outputs
// assumes it is bound to intc_core and sees only its ports
`timescale 1ns/10ps
module intc_core_sva
  import intc_pkg::*;
(
  input wire logic              clk,
  input wire logic              reset_n,
  input wire logic              wait_n,
  input wire logic              vector_fetch_strobe_n,
  input wire logic [CS_N-1:0]   chip_select_outs,
  input wire logic [LVL_W-1:0]  accepted_level_out,
  input wire logic              exc_start,
  input wire logic [LVL_W-1:0]  exc_level,
  input wire logic [31:0]       exc_addr,
  input wire logic [LVL_W-1:0]  status_mask_field
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence fetch_s;
    !vector_fetch_strobe_n;
  endsequence
  sequence fetch_end_s;
    !vector_fetch_strobe_n ##1 vector_fetch_strobe_n;
  endsequence
  cs_in_fetch_a: assert property (fetch_s |-> chip_select_outs == 5'h1F)
    else $error("chip select low in fetch");
  level_idle_a: assert property (vector_fetch_strobe_n |-> accepted_level_out == 4'h0)
    else $error("level out outside fetch");
  level_fetch_a: assert property (fetch_s |-> accepted_level_out != 4'h0)
    else $error("level zero in fetch");
  wait_hold_a: assert property (!vector_fetch_strobe_n && !wait_n |=> fetch_s)
    else $error("fetch ended under wait");
  no_prog_wait_a: assert property ($fell(vector_fetch_strobe_n) && wait_n |=>
    vector_fetch_strobe_n) else $error("fetch stretched without wait");
  fetch_issue_a: assert property (fetch_end_s |=> exc_start)
    else $error("no exception after fetch");
  mask_load_a: assert property (exc_start |-> status_mask_field == exc_level)
    else $error("mask not loaded");
  addr_align_a: assert property (exc_start |-> exc_addr[1:0] == 2'b00)
    else $error("handler address not word aligned");
endmodule
bind intc_core intc_core_sva u_sva (.clk(clk), .reset_n(reset_n), .wait_n(wait_n),
  .vector_fetch_strobe_n(vector_fetch_strobe_n), .chip_select_outs(chip_select_outs),
  .accepted_level_out(accepted_level_out), .exc_start(exc_start), .exc_level(exc_level),
  .exc_addr(exc_addr), .status_mask_field(status_mask_field));

//--- tb/ext_vec_model.sv
// outside vector supply: answers each fetch with a level-coded vector
// assumes the fetch strobe and level lines of the core
`timescale 1ns/10ps
module ext_vec_model (
  input  wire logic       clk,
  input  wire logic       strobe_n,
  input  wire logic [3:0] level,
  input  wire logic [3:0] stall,
  output logic [7:0]      vec,
  output logic            wait_n
);
  logic [3:0] cnt = 4'h0;
  logic       t   = 1'b0;
  always @(posedge clk) begin
    t   <= ~t;
    cnt <= strobe_n ? 4'h0 : cnt + 4'h1;
  end
  // top line low; toggling junk outside a fetch
  assign vec    = strobe_n ? {8{t}} : {4'h5, level};
  assign wait_n = strobe_n | (cnt >= stall);
endmodule

//--- tb/external_irq_priority_vector_ctrl_tb_top.sv
// bench of the controller: table of request cases, then hand cases
// assumes the vector supply model and the bound checker
`timescale 1ns/10ps
module external_irq_priority_vector_ctrl_tb_top
  import intc_pkg::*;
;
  logic        clk, reset_n, ce, wr, rd, nmi_pin, wait_n, fs_n, exc_start;
  logic [7:0]  addr, vin, exc_vector;
  logic [15:0] wdata, rdata;
  logic [3:0]  request_pins, lvl_out, exc_level, mask, stall, lv;
  logic [4:0]  cs_out;
  logic [31:0] periph_req, exc_addr, r;
  int          error_cnt, n_checks, n_exc, i, m, c0;
  logic [31:0] rows [7] = '{32'h0000_0F47, 32'h0000_E140, 32'h0000_5A45, 32'h0001_5A5A,
                           32'h0002_BA45, 32'h0003_E555, 32'h0002_6542};
  intc_core u_dut (.clk(clk), .reset_n(reset_n), .ce(ce), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .nmi_pin(nmi_pin), .request_pins(request_pins),
    .periph_req(periph_req), .vector_in_lines(vin), .wait_n(wait_n),
    .bus_chip_select_n(5'h0A), .chip_select_outs(cs_out), .accepted_level_out(lvl_out),
    .vector_fetch_strobe_n(fs_n), .exc_start(exc_start), .exc_level(exc_level),
    .exc_vector(exc_vector), .exc_addr(exc_addr), .status_mask_field(mask));
  ext_vec_model u_ext (.clk(clk), .strobe_n(fs_n), .level(lvl_out), .stall(stall),
    .vec(vin), .wait_n(wait_n));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(negedge clk) if (exc_start === 1'b1) n_exc++;
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task complete_run;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task wrr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk) begin addr <= a; wdata <= d; wr <= 1'b1; end
    @(posedge clk) wr <= 1'b0;
  endtask
  task rdc(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk) begin addr <= a; rd <= 1'b1; end
    @(posedge clk) rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task wait_exc;
    int k;
    for (k = 0; k < 40 && exc_start !== 1'b1; k++) begin
      @(posedge clk);
      #1 if (fs_n === 1'b0) lv = lvl_out;
    end
    chk(exc_start, 1'b1);
  endtask
  initial begin
    #500000;
    error_cnt++;
    complete_run();
  end
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    reset_n = 1'b0; ce = 1'b1; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 16'h0000;
    nmi_pin = 1'b1; request_pins = 4'hF; periph_req = 32'h0; stall = 4'h0; lv = 4'h0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    #1 chk(mask, 4'hF);
    chk(cs_out, 5'h0A);
    rdc(OFS_PRI_A, 16'h0000);
    rdc(8'h30, 16'h0000);
    wrr(OFS_EXT_PRI, 16'h3A95);
    for (i = 0; i < 7; i++) begin
      r = rows[i];
      wrr(OFS_CTRL, r[31:16]);
      wrr(OFS_MASK, 16'h0000);
      @(posedge clk) begin request_pins <= r[15:12]; stall <= 4'(i % 3); end
      wait_exc();
      chk(exc_level, r[11:8]);
      chk(exc_vector, r[7:0]);
      chk(exc_addr, {r[7:0], 2'b00});
      if (r[16]) chk(lv, r[11:8]);
      @(posedge clk) request_pins <= 4'hF;
    end
    wrr(OFS_VBR_LO, 16'h1000);
    wrr(OFS_PRI_A, 16'h7000);
    wrr(8'h40, 16'h0021);
    wrr(8'h42, 16'h002C);
    rdc(8'h42, 16'h002C);
    wrr(OFS_MASK, 16'h0000);
    @(posedge clk) periph_req <= 32'h3;
    wait_exc();
    chk(exc_vector, 8'h21);
    chk(exc_addr, 32'h0000_1084);
    chk(mask, 4'h7);
    @(posedge clk) periph_req <= 32'h2;
    wrr(OFS_MASK, 16'h0000);
    wait_exc();
    chk(exc_vector, 8'h2C);
    @(posedge clk) periph_req <= 32'h10;
    wrr(OFS_MASK, 16'h0000);
    c0 = n_exc;
    repeat (10) @(posedge clk);
    chk(n_exc - c0, 0);
    @(posedge clk) begin periph_req <= 32'h0; nmi_pin <= 1'b0; end
    wait_exc();
    chk(exc_vector, NMI_VECTOR);
    chk(exc_level, 4'hF);
    wrr(OFS_CTRL, 16'h0002);
    for (m = 1; m < 4; m++) begin
      wrr(OFS_SENSE, 16'(m));
      wrr(OFS_MASK, 16'h0000);
      c0 = n_exc;
      @(posedge clk) request_pins <= 4'hE;
      repeat (8) @(posedge clk);
      chk(n_exc - c0, m % 2);
      wrr(OFS_MASK, 16'h0000);
      @(posedge clk) request_pins <= 4'hF;
      repeat (8) @(posedge clk);
      chk(n_exc - c0, m % 2 + m / 2);
    end
    complete_run();
  end
endmodule
